// ---- verilog/smoke_detector_supervisor.v ----
`timescale 1ns/1ps
`include "smoke_sup_defines.vh"
module smoke_detector_supervisor #(
	parameter SW = 12,
	parameter FW = 14,
	parameter AFW = 12,
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter EXT_LONG_TICKS = `EXT_LONG_TICKS,
	parameter CONFIRM_TICKS = `CONFIRM_TICKS,
	parameter HWRST_TICKS = `HWRST_TICKS,
	parameter FAN_BLOCK_RPM = 2000,
	parameter RAMP_STEP = 1,
	parameter AF_TOL = 100
) (
	input  wire           clk_i,
	input  wire           rst_n_i,
	input  wire [SW-1:0]  smoke_level_i,
	input  wire [SW-1:0]  alarm_limit_i,
	input  wire [FW-1:0]  fan_rpm_i,
	input  wire [AFW-1:0] airflow_i,
	input  wire [15:0]    af_delay_ticks_i,
	input  wire           undervolt_i,
	input  wire           sensor_fault_i,
	input  wire           loop_link_ok_i,
	input  wire           relay_link_ok_i,
	input  wire           loop_fitted_i,
	input  wire           relay_fitted_i,
	input  wire           loop_reset_cmd_i,
	input  wire           card_present_i,
	input  wire           reset_key_i,
	input  wire           set_key_i,
	input  wire           ext_reset_i,
	input  wire [4:0]     mode_sw_i,
	input  wire [9:0]     log_raddr_i,
	output reg            alarm_relay_o,
	output reg            fault_relay_o,
	output reg  [2:0]     pre_signal_o,
	output reg            oc_alarm_out_n_o,
	output reg            oc_fault_out_n_o,
	output reg            fault_led_o,
	output reg            mode_led_flash_o,
	output reg            fan_enable_o,
	output reg  [FW-1:0]  fan_target_o,
	output reg  [AFW-1:0] airflow_ref_o,
	output reg            inactive_o,
	output reg            isolated_o,
	output reg            card_log_wr_o,
	output reg  [15:0]    card_log_data_o,
	output reg  [19:0]    card_log_count_o,
	output reg  [15:0]    log_rdata_o
);
	localparam [FW-1:0] FAN_TARGET = `FAN_TARGET_RPM;
	localparam [19:0]   CARD_MAX   = `LOG_CARD_DEPTH;
	localparam [3:0] MS_IDLE = 4'b0001;
	localparam [3:0] MS_WAIT = 4'b0010;
	localparam [3:0] MS_WAIT2 = 4'b0100;
	localparam [3:0] MS_FAULT = 4'b1000;

	// prescaler
	reg [17:0] pre_cnt;
	reg        tick;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pre_cnt <= 18'h00000;
			tick    <= 1'b0;
		end else if (pre_cnt == TICK_CYCLES[17:0] - 18'h00001) begin
			pre_cnt <= 18'h00000;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 18'h00001;
			tick    <= 1'b0;
		end
	end

	wire rkey;
	wire skey;
	wire ext;
	input_conditioner #(.DB_TICKS(`DEBOUNCE_TICKS)) u_rkey (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tick_i(tick), .raw_i(reset_key_i), .clean_o(rkey));
	input_conditioner #(.DB_TICKS(`DEBOUNCE_TICKS)) u_skey (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tick_i(tick), .raw_i(set_key_i), .clean_o(skey));
	input_conditioner #(.DB_TICKS(`DEBOUNCE_TICKS)) u_ext (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tick_i(tick), .raw_i(ext_reset_i), .clean_o(ext));

	reg rkey_d;
	reg skey_d;
	reg ext_d;
	reg [1:0] lcmd_s;
	reg lcmd_d;
	reg [4:0] mode_s1;
	reg [4:0] mode_s2;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			rkey_d  <= 1'b0;
			skey_d  <= 1'b0;
			ext_d   <= 1'b0;
			lcmd_s  <= 2'b00;
			lcmd_d  <= 1'b0;
			mode_s1 <= 5'h01;
			mode_s2 <= 5'h01;
		end else begin
			rkey_d  <= rkey;
			skey_d  <= skey;
			ext_d   <= ext;
			lcmd_s  <= {lcmd_s[0], loop_reset_cmd_i};
			lcmd_d  <= lcmd_s[1];
			mode_s1 <= mode_sw_i;
			mode_s2 <= mode_s1;
		end
	end
	wire set_press = skey & ~skey_d;

	// external reset: short = state reset, held past limit = inactive
	reg [15:0] ext_cnt;
	reg        ext_long;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ext_cnt  <= 16'h0000;
			ext_long <= 1'b0;
		end else if (!ext) begin
			ext_cnt  <= 16'h0000;
			ext_long <= 1'b0;
		end else if (tick && !ext_long) begin
			if (ext_cnt >= EXT_LONG_TICKS[15:0] - 16'h0001)
				ext_long <= 1'b1;
			else
				ext_cnt <= ext_cnt + 16'h0001;
		end
	end
	wire ext_short = ~ext & ext_d & ~ext_long;
	wire state_reset = (rkey & ~rkey_d) | ext_short | (lcmd_s[1] & ~lcmd_d);

	// mode switch with confirmation window
	reg [3:0]  ms;
	reg [4:0]  mode_act;
	reg [15:0] conf_cnt;
	reg        init_req;
	wire mode_chg = (mode_s2 != mode_act);
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ms       <= MS_IDLE;
			mode_act <= 5'h01;
			conf_cnt <= 16'h0000;
			init_req <= 1'b0;
		end else begin
			init_req <= 1'b0;
			case (ms)
			MS_IDLE: begin
				conf_cnt <= 16'h0000;
				if (mode_chg)
					ms <= MS_WAIT;
			end
			MS_WAIT, MS_WAIT2, MS_FAULT: begin
				if (set_press) begin
					mode_act <= mode_s2;
					init_req <= (mode_s2[3:0] == `MODE_INIT) && !mode_s2[4];
					ms       <= MS_IDLE;
				end else if (!mode_chg)
					ms <= MS_IDLE;
				else if (tick && ms != MS_FAULT) begin
					if (conf_cnt >= CONFIRM_TICKS[15:0] - 16'h0001) begin
						conf_cnt <= 16'h0000;
						ms <= (ms == MS_WAIT) ? MS_WAIT2 : MS_FAULT;
					end else
						conf_cnt <= conf_cnt + 16'h0001;
				end
			end
			default: ms <= MS_IDLE;
			endcase
		end
	end
	// reserved positions 8..31 act like operation
	wire mode_rsv = mode_act[4] | mode_act[3];
	wire m_inact = !mode_rsv && mode_act[3:0] == `MODE_INACTIVE;
	wire m_iso   = !mode_rsv && mode_act[3:0] == `MODE_ISOLATE;
	wire m_tpre  = !mode_rsv && mode_act[3:0] == `MODE_TEST_PRE;
	wire m_talm  = !mode_rsv && mode_act[3:0] == `MODE_TEST_ALM;
	wire m_tflt  = !mode_rsv && mode_act[3:0] == `MODE_TEST_FLT;
	wire m_logoff = !mode_rsv && mode_act[3:0] == `MODE_LOGOFF;

	// thresholds as fractions of the alarm limit
	wire [SW+6:0] al_w = {7'h00, alarm_limit_i};
	wire [SW+6:0] sm_w = {7'h00, smoke_level_i} * 19'd100;
	wire c_alm  = smoke_level_i > alarm_limit_i;
	wire c_pre1 = sm_w > al_w * `PRE1_PCT;
	wire c_pre2 = sm_w > al_w * `PRE2_PCT;
	wire c_pre3 = sm_w > al_w * `PRE3_PCT;

	// fan: hold-off after restart, slow ramp
	reg [15:0] start_cnt;
	reg        fan_block;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			fan_enable_o <= 1'b0;
			fan_target_o <= {FW{1'b0}};
			start_cnt    <= 16'h0000;
			fan_block    <= 1'b0;
		end else begin
			if (start_cnt < HWRST_TICKS[15:0]) begin
				if (tick)
					start_cnt <= start_cnt + 16'h0001;
			end else if (!fan_block) begin
				fan_enable_o <= 1'b1;
				if (tick && fan_target_o < FAN_TARGET)
					fan_target_o <= fan_target_o + RAMP_STEP[FW-1:0];
				if (fan_target_o == FAN_TARGET && fan_rpm_i < FAN_BLOCK_RPM[FW-1:0]) begin
					fan_block    <= 1'b1;
					fan_enable_o <= 1'b0;
				end
			end
		end
	end

	// airflow deviation persistence and reference capture
	reg [15:0] af_cnt;
	reg        af_fault_c;
	reg        ref_valid;
	wire [AFW:0] af_diff = (airflow_i > airflow_ref_o) ? {1'b0, airflow_i - airflow_ref_o}
		: {1'b0, airflow_ref_o - airflow_i};
	wire af_dev = ref_valid && fan_enable_o && (af_diff > AF_TOL[AFW:0]);
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			af_cnt     <= 16'h0000;
			af_fault_c <= 1'b0;
		end else if (!af_dev) begin
			af_cnt     <= 16'h0000;
			af_fault_c <= 1'b0;
		end else if (tick && !af_fault_c) begin
			if (af_cnt >= af_delay_ticks_i)
				af_fault_c <= 1'b1;
			else
				af_cnt <= af_cnt + 16'h0001;
		end
	end
	// reference kept outside reset so a restart does not lose it
	always @(posedge clk_i) begin
		if (init_req && fan_enable_o)
			airflow_ref_o <= airflow_i;
	end
	reg init_fail;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ref_valid <= 1'b0;
			init_fail <= 1'b0;
		end else if (init_req) begin
			ref_valid <= fan_enable_o;
			init_fail <= !fan_enable_o;
		end else if (state_reset && ref_valid)
			init_fail <= 1'b0;
	end

	// causes and latched events
	localparam NEV = 10;
	wire [NEV-1:0] cause = {init_fail, (ms == MS_FAULT), sensor_fault_i,
		relay_fitted_i & ~relay_link_ok_i & ~m_logoff,
		loop_fitted_i & ~loop_link_ok_i & ~m_logoff,
		undervolt_i,
		fan_block, af_fault_c,
		c_alm | m_talm, c_pre1 | m_tpre};
	reg [NEV-1:0] latched;
	reg [NEV-1:0] cause_d;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			latched <= {NEV{1'b0}};
			cause_d <= {NEV{1'b0}};
		end else begin
			cause_d <= cause;
			// set wins: a live cause stays latched through a reset
			if (state_reset)
				latched <= cause;
			else
				latched <= latched | cause;
		end
	end
	reg [2:0] pre_lat;
	always @(posedge clk_i) begin
		if (!rst_n_i)
			pre_lat <= 3'b000;
		else if (state_reset)
			pre_lat <= {c_pre3, c_pre2, c_pre1 | m_tpre};
		else
			pre_lat <= pre_lat | {c_pre3, c_pre2, c_pre1 | m_tpre};
	end

	wire any_fault = (|latched[NEV-1:2]) | m_tflt | ext_long | m_inact;
	reg [15:0] hw_cnt;
	always @(posedge clk_i) begin
		if (!rst_n_i)
			hw_cnt <= 16'h0000;
		else if (tick && hw_cnt < HWRST_TICKS[15:0])
			hw_cnt <= hw_cnt + 16'h0001;
	end
	wire hw_flt = hw_cnt < HWRST_TICKS[15:0];
	wire quiet = m_iso | m_inact | ext_long;

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			alarm_relay_o    <= 1'b0;
			fault_relay_o    <= 1'b0;
			pre_signal_o     <= 3'b000;
			oc_alarm_out_n_o <= 1'b1;
			oc_fault_out_n_o <= 1'b1;
			fault_led_o      <= 1'b0;
			mode_led_flash_o <= 1'b0;
			inactive_o       <= 1'b0;
			isolated_o       <= 1'b0;
		end else begin
			alarm_relay_o    <= latched[1] & ~quiet;
			pre_signal_o     <= quiet ? 3'b000 : pre_lat;
			// energised relay means healthy
			fault_relay_o    <= ~(any_fault | hw_flt);
			fault_led_o      <= any_fault;
			oc_alarm_out_n_o <= ~(latched[1] & ~quiet);
			oc_fault_out_n_o <= ~(any_fault | hw_flt);
			mode_led_flash_o <= (ms == MS_WAIT2);
			inactive_o       <= m_inact | ext_long;
			isolated_o       <= m_iso;
		end
	end

	// event log: record rising edges of causes
	wire [NEV-1:0] rise = cause & ~cause_d;
	reg [3:0] ev_code;
	integer   i;
	always @* begin
		ev_code = 4'h0;
		for (i = 0; i < NEV; i = i + 1)
			if (rise[i])
				ev_code = i[3:0] + 4'h1;
	end
	reg [15:0] ev_time;
	always @(posedge clk_i) begin
		if (!rst_n_i)
			ev_time <= 16'h0000;
		else if (tick)
			ev_time <= ev_time + 16'h0001;
	end
	wire        log_wr = |rise;
	wire [15:0] log_word = {ev_code, ev_time[11:0]};
	wire [15:0] mem_rd;
	event_log_mem #(.DEPTH(`LOG_INT_DEPTH), .AW(10), .DW(16)) u_log (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(log_wr), .wdata_i(log_word),
		.raddr_i(log_raddr_i), .rdata_o(mem_rd), .wptr_o(), .wrapped_o());
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			log_rdata_o      <= 16'h0000;
			card_log_wr_o    <= 1'b0;
			card_log_data_o  <= 16'h0000;
			card_log_count_o <= 20'h00000;
		end else begin
			log_rdata_o   <= mem_rd;
			card_log_wr_o <= 1'b0;
			if (log_wr && card_present_i && !m_logoff && card_log_count_o < CARD_MAX) begin
				card_log_wr_o    <= 1'b1;
				card_log_data_o  <= log_word;
				card_log_count_o <= card_log_count_o + 20'h00001;
			end
		end
	end
endmodule

// ---- verilog/smoke_sup_defines.vh ----
`ifndef SMOKE_SUP_DEFINES_VH
`define SMOKE_SUP_DEFINES_VH
`define CLK_HZ          200000000
`define TICK_MS         1
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define EXT_SHORT_MS    20000
`define EXT_LONG_TICKS  (`EXT_SHORT_MS / `TICK_MS)
`define CONFIRM_MS      5000
`define CONFIRM_TICKS   (`CONFIRM_MS / `TICK_MS)
`define HWRST_FLT_MS    1000
`define HWRST_TICKS     (`HWRST_FLT_MS / `TICK_MS)
`define DEBOUNCE_TICKS  20
`define FAN_TARGET_RPM  5250
`define PRE1_PCT        30
`define PRE2_PCT        50
`define PRE3_PCT        70
`define LOG_INT_DEPTH   1000
`define LOG_CARD_DEPTH  640000
`define MODE_INIT       4'h0
`define MODE_OPER       4'h1
`define MODE_ISOLATE    4'h2
`define MODE_TEST_PRE   4'h3
`define MODE_TEST_ALM   4'h4
`define MODE_TEST_FLT   4'h5
`define MODE_LOGOFF     4'h6
`define MODE_INACTIVE   4'h7
`endif

// ---- verilog/input_conditioner.v ----
`timescale 1ns/1ps
// two-flop sync then debounce on the prescaled tick
module input_conditioner #(
	parameter DB_TICKS = 20
) (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire tick_i,
	input  wire raw_i,
	output reg  clean_o
);
	reg        sync_a;
	reg        sync_b;
	reg [15:0] cnt;

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync_a  <= 1'b0;
			sync_b  <= 1'b0;
			cnt     <= 16'h0000;
			clean_o <= 1'b0;
		end else begin
			sync_a <= raw_i;
			sync_b <= sync_a;
			if (sync_b == clean_o)
				cnt <= 16'h0000;
			else if (tick_i) begin
				if (cnt >= DB_TICKS[15:0] - 16'h0001) begin
					clean_o <= sync_b;
					cnt     <= 16'h0000;
				end else
					cnt <= cnt + 16'h0001;
			end
		end
	end
endmodule

// ---- verilog/event_log_mem.v ----
`timescale 1ns/1ps
// circular event store; oldest entries overwritten, no erase port
module event_log_mem #(
	parameter DEPTH = 1000,
	parameter AW    = 10,
	parameter DW    = 16
) (
	input  wire          clk_i,
	input  wire          rst_n_i,
	input  wire          wr_i,
	input  wire [DW-1:0] wdata_i,
	input  wire [AW-1:0] raddr_i,
	output reg  [DW-1:0] rdata_o,
	output reg  [AW-1:0] wptr_o,
	output reg           wrapped_o
);
	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge clk_i) begin
		if (wr_i)
			mem[wptr_o] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wptr_o    <= {AW{1'b0}};
			wrapped_o <= 1'b0;
		end else if (wr_i) begin
			if (wptr_o == DEPTH[AW-1:0] - 1'b1) begin
				wptr_o    <= {AW{1'b0}};
				wrapped_o <= 1'b1;
			end else
				wptr_o <= wptr_o + 1'b1;
		end
	end
endmodule

// ---- verif/supervisor_checker_sva.sv ----
`timescale 1ns/1ps
module supervisor_checker #(
	parameter SW = 12,
	parameter FW = 14
) (
	input logic          clk_i,
	input logic          rst_n_i,
	input logic [SW-1:0] smoke_level_i,
	input logic [SW-1:0] alarm_limit_i,
	input logic [FW-1:0] fan_rpm_i,
	input logic          undervolt_i,
	input logic [4:0]    mode_sw_i,
	input logic          alarm_relay_o,
	input logic          fault_relay_o,
	input logic [2:0]    pre_signal_o,
	input logic          oc_alarm_out_n_o,
	input logic          oc_fault_out_n_o,
	input logic          fault_led_o,
	input logic          fan_enable_o,
	input logic [FW-1:0] fan_target_o,
	input logic          inactive_o,
	input logic          isolated_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// isolate and inactive refuse alarms, so only plain operation is judged
	wire        run  = mode_sw_i == 5'h01 && !isolated_o && !inactive_o;
	wire        over = run && smoke_level_i > alarm_limit_i;
	wire [31:0] lvl  = smoke_level_i * 32'h64;
	wire [31:0] half = alarm_limit_i * 32'h32;
	wire        stuck = fan_enable_o && fan_target_o == 14'h1482 && fan_rpm_i < 14'h07D0;
	oc_alarm_a: assert property (oc_alarm_out_n_o == !alarm_relay_o)
		else $error("alarm line disagrees with relay");
	oc_fault_a: assert property (!oc_fault_out_n_o |-> !fault_relay_o)
		else $error("fault line on with relay energised");
	fault_led_a: assert property (fault_led_o |-> !fault_relay_o)
		else $error("fault lamp on with relay energised");
	inactive_fault_a: assert property (inactive_o |-> !fault_relay_o)
		else $error("inactive without fault");
	undervolt_fault_a: assert property (undervolt_i [*4] |-> !fault_relay_o && fault_led_o)
		else $error("low supply without fault");
	alarm_set_a: assert property (over [*4] |-> alarm_relay_o)
		else $error("smoke over limit without alarm");
	pre_mid_a: assert property ((run && lvl > half) [*4] |-> pre_signal_o[1])
		else $error("second pre-signal missing");
	fan_block_a: assert property (stuck |-> ##[1:4] !fan_enable_o)
		else $error("blocked fan still supplied");
	restart_hold_a: assert property ($rose(rst_n_i) |-> (!fault_relay_o && !fan_enable_o) [*8])
		else $error("relay or fan up right after restart");
endmodule

// ---- verif/fire_panel_model.sv ----
`timescale 1ns/1ps
// panel side: reads the fault contact, drives the external reset line
module fire_panel_model (
	input  logic clk_i,
	input  logic hold_i,
	input  logic fault_relay_i,
	output logic ext_reset_o,
	output logic fault_seen_o
);
	initial ext_reset_o = 1'h0;
	always @(posedge clk_i) begin
		ext_reset_o <= hold_i;
	end
	// a dropped contact reads as fault, so a dead detector also shows one
	assign fault_seen_o = !fault_relay_i;
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	reg         clk_i = 1'h0;
	reg         rst_n_i = 1'h0;
	reg  [11:0] smoke = 12'h000;
	reg  [11:0] limit = 12'h3E8;
	reg  [11:0] air = 12'h200;
	reg  [13:0] rpm = 14'h1482;
	reg  [15:0] delay = 16'h0005;
	reg  [3:0]  cause = 4'h0;
	reg         lcmd = 1'h0;
	reg         rkey = 1'h0;
	reg         skey = 1'h0;
	reg         hold = 1'h0;
	reg  [4:0]  mode = 5'h01;
	reg         fit = 1'h1;
	reg         card = 1'h1;
	wire        alm, flt, oca, ocf, led, flash, fan, inact, ext, pflt, iso;
	wire [2:0]  pre;
	wire [13:0] tgt;
	wire [11:0] ref_v;
	integer     errors = 0;
	integer     total_checks = 0;
	// smoke against a limit of 1000 and the {alarm, pre-signals} it must give
	localparam [71:0] LEVELS = {12'h44C, 12'h3E8, 12'h320, 12'h258, 12'h12D, 12'h12C};
	localparam [23:0] EXPECT = {4'hF, 4'h7, 4'h7, 4'h3, 4'h1, 4'h0};
	smoke_detector_supervisor #(
		.TICK_CYCLES(4), .EXT_LONG_TICKS(40), .CONFIRM_TICKS(5), .HWRST_TICKS(3),
		.RAMP_STEP(1050)
	) smoke_detector_supervisor_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .smoke_level_i(smoke), .alarm_limit_i(limit),
		.fan_rpm_i(rpm), .airflow_i(air), .af_delay_ticks_i(delay), .undervolt_i(cause[0]),
		.loop_link_ok_i(!cause[1]), .relay_link_ok_i(!cause[2]), .sensor_fault_i(cause[3]),
		.loop_fitted_i(fit), .relay_fitted_i(fit), .loop_reset_cmd_i(lcmd),
		.card_present_i(card), .reset_key_i(rkey), .set_key_i(skey), .ext_reset_i(ext),
		.mode_sw_i(mode), .log_raddr_i(10'h000), .alarm_relay_o(alm), .fault_relay_o(flt),
		.pre_signal_o(pre), .oc_alarm_out_n_o(oca), .oc_fault_out_n_o(ocf),
		.fault_led_o(led), .mode_led_flash_o(flash), .fan_enable_o(fan),
		.fan_target_o(tgt), .airflow_ref_o(ref_v), .inactive_o(inact), .isolated_o(iso),
		.card_log_wr_o(), .card_log_data_o(), .card_log_count_o(), .log_rdata_o()
	);
	fire_panel_model fire_panel_model_inst (
		.clk_i(clk_i), .hold_i(hold), .fault_relay_i(flt), .ext_reset_o(ext),
		.fault_seen_o(pflt)
	);
	always #2.5 clk_i = ~clk_i;
	task check(input [31:0] got, input [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// outputs are read at the falling edge, well clear of the launching edge
	task cyc(input integer n);
		repeat (n) @(negedge clk_i);
	endtask
	// 24 ticks down and up: past the 20-tick debounce on both edges
	task press(input integer sel);
		@(posedge clk_i);
		if (sel == 0)
			rkey <= 1'h1;
		else
			skey <= 1'h1;
		cyc(96);
		@(posedge clk_i);
		rkey <= 1'h0;
		skey <= 1'h0;
		cyc(96);
	endtask
	task board_restart_key;
		integer n;
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'h1;
		cyc(2);
		check(flt, 0);
		check(fan, 0);
		n = 0;
		while (!(flt === 1'b1 && tgt === 14'h1482) && n < 400) begin
			cyc(1);
			n++;
		end
		check(n >= 10 && n < 400, 1);
		if (n >= 400)
			complete_run;
		check(fan, 1);
		check(iso, 0);
		$display("restart done");
	endtask
	task test_levels;
		integer i;
		for (i = 0; i < 6; i++) begin
			@(posedge clk_i);
			smoke <= LEVELS[i*12 +: 12];
			cyc(4);
			check({alm, pre}, EXPECT[i*4 +: 4]);
			check(oca, !EXPECT[i*4+3]);
			press(0);
			check({alm, pre}, EXPECT[i*4 +: 4]);
			check(fan, 1);
			@(posedge clk_i);
			smoke <= 12'h000;
			press(0);
			check({alm, pre}, 0);
		end
		$display("levels done");
	endtask
	task test_faults;
		integer k;
		for (k = 0; k < 4; k++) begin
			@(posedge clk_i);
			cause <= 4'h1 << k;
			cyc(4);
			check({flt, ocf, led, pflt}, 4'h3);
			@(posedge clk_i);
			cause <= 4'h0;
			cyc(4);
			check(flt, 0);
			@(posedge clk_i);
			lcmd <= 1'h1;
			repeat (3) @(posedge clk_i);
			lcmd <= 1'h0;
			cyc(8);
			check({flt, led}, 2'h2);
		end
		$display("faults done");
	endtask
	task test_ext;
		@(posedge clk_i);
		smoke <= 12'h44C;
		cyc(4);
		@(posedge clk_i);
		smoke <= 12'h000;
		hold <= 1'h1;
		cyc(264);
		check({inact, flt, alm}, 3'h4);
		@(posedge clk_i);
		hold <= 1'h0;
		cyc(96);
		check({inact, alm}, 2'h1);
		@(posedge clk_i);
		hold <= 1'h1;
		cyc(96);
		@(posedge clk_i);
		hold <= 1'h0;
		cyc(96);
		check({inact, alm}, 2'h0);
		$display("external reset done");
	endtask
	task test_mode;
		@(posedge clk_i);
		mode <= 5'h00;
		cyc(28);
		check({flash, flt}, 2'h3);
		cyc(24);
		check(flt, 0);
		press(1);
		// rotary fault stays latched until a state reset
		press(0);
		check(flt, 1);
		check(ref_v, 12'h200);
		@(posedge clk_i);
		mode <= 5'h01;
		air <= 12'h300;
		cyc(12);
		check(ref_v, 12'h200);
		press(1);
		check(flt, 0);
		@(posedge clk_i);
		air <= 12'h200;
		press(0);
		@(posedge clk_i);
		air <= 12'h300;
		cyc(12);
		check(flt, 1);
		cyc(24);
		check(flt, 0);
		@(posedge clk_i);
		air <= 12'h200;
		press(0);
		check(flt, 1);
		$display("mode done");
	endtask
	task test_fan;
		@(posedge clk_i);
		rpm <= 14'h07D0;
		cyc(6);
		check(fan, 1);
		@(posedge clk_i);
		rpm <= 14'h07CF;
		cyc(6);
		check({fan, pflt}, 2'h1);
		@(posedge clk_i);
		rpm <= 14'h1482;
		press(0);
		check(fan, 0);
		board_restart_key;
		check(ref_v, 12'h200);
		$display("fan done");
	endtask
	initial begin
		board_restart_key;
		test_levels;
		test_faults;
		test_ext;
		test_mode;
		test_fan;
		complete_run;
	end
endmodule
bind smoke_detector_supervisor supervisor_checker #(.SW(SW), .FW(FW)) supervisor_checker_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .smoke_level_i(smoke_level_i),
	.alarm_limit_i(alarm_limit_i), .fan_rpm_i(fan_rpm_i), .undervolt_i(undervolt_i),
	.mode_sw_i(mode_sw_i), .alarm_relay_o(alarm_relay_o), .fault_relay_o(fault_relay_o),
	.pre_signal_o(pre_signal_o), .oc_alarm_out_n_o(oc_alarm_out_n_o),
	.oc_fault_out_n_o(oc_fault_out_n_o), .fault_led_o(fault_led_o),
	.fan_enable_o(fan_enable_o), .fan_target_o(fan_target_o), .inactive_o(inactive_o),
	.isolated_o(isolated_o)
);
